// ---- src/hsb_pkg.sv ----
package hsb_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] HSB_IDX_PARITY_SEL = 8'ha0;
  localparam logic [7:0] HSB_IDX_CHAN1_MASK = 8'ha1;
  localparam logic [7:0] HSB_IDX_CHAN2_MASK = 8'ha2;
  localparam logic [7:0] HSB_IDX_CHAN3_MASK = 8'ha3;
  localparam logic [7:0] HSB_IDX_CHAN1_TX_SLOTS = 8'ha4;
  localparam logic [7:0] HSB_IDX_CHAN1_RX_SLOTS = 8'ha5;
  localparam logic [7:0] HSB_IDX_CHAN2_SLOTS = 8'ha6;
  localparam logic [7:0] HSB_IDX_CHAN3_SLOTS = 8'ha7;
  localparam logic [7:0] HSB_IDX_STATUS = 8'ha8;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int HSB_NUM_CHAN = 3;
  localparam int HSB_PAR_W = 2;
  localparam int HSB_MASK_W = 8;
  localparam int HSB_SLOT_W = 32;
  localparam int HSB_STAT_ODD_BIT = 0;
  localparam int HSB_STAT_ALIGNED_BIT = 1;
  localparam logic [1:0] HSB_PAR_BOTH = 2'h0;
  localparam logic [1:0] HSB_PAR_ODD = 2'h1;
  localparam logic [1:0] HSB_PAR_EVEN = 2'h2;
  localparam logic [5:0] HSB_PARITY_RESET = 6'h00;
  localparam logic [7:0] HSB_MASK_RESET = 8'hff;
  localparam logic [31:0] HSB_SLOTS_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [2:0] bitpos;
  } hsb_pos_t;

  typedef struct packed {
    logic [31:0] rx_slots;
    logic [31:0] tx_slots;
    logic [7:0] mask;
    logic [1:0] parity;
  } hsb_chan_cfg_t;

endpackage

// ---- src/hsb_frame_parity.sv ----
module hsb_frame_parity
  import hsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic frame_start,
  input wire logic mf_start,
  output logic odd_frame,
  output logic aligned
);

  // Multiframe start forces odd; every other frame start flips parity
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      odd_frame <= 1'b1;
    end else if (mf_start) begin
      odd_frame <= 1'b1;
    end else if (frame_start) begin
      odd_frame <= ~odd_frame;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aligned <= 1'b0;
    end else if (mf_start) begin
      aligned <= 1'b1;
    end
  end

endmodule

// ---- src/hsb_chan_gate.sv ----
module hsb_chan_gate
  import hsb_pkg::*;
(
  input hsb_chan_cfg_t cfg,
  input hsb_pos_t pos,
  input wire logic odd_frame,
  output logic rx_sel,
  output logic tx_sel
);

  logic frame_ok;
  logic bit_ok;

  // Code 11 is left unused: such a channel takes no frame at all
  always_comb begin
    case (cfg.parity)
      HSB_PAR_BOTH: frame_ok = 1'b1;
      HSB_PAR_ODD: frame_ok = odd_frame;
      HSB_PAR_EVEN: frame_ok = ~odd_frame;
      default: frame_ok = 1'b0;
    endcase
  end

  assign bit_ok = pos.valid & cfg.mask[pos.bitpos] & frame_ok;
  assign rx_sel = bit_ok & cfg.rx_slots[pos.slot];
  assign tx_sel = bit_ok & cfg.tx_slots[pos.slot];

endmodule

// ---- src/hsb_slot_bit_select.sv ----
module hsb_slot_bit_select
  import hsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  input wire logic mf_start,
  input hsb_pos_t line_pos,
  input wire logic line_rx_bit,
  input wire logic line_tx_in,
  input wire logic [2:0] chan_tx_bit,
  output logic line_tx_out,
  output logic [2:0] chan_rx_valid,
  output logic [2:0] chan_rx_bit,
  output logic [2:0] chan_tx_pull
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [5:0] parity_sel;
  logic [7:0] chan_mask [HSB_NUM_CHAN];
  logic [31:0] chan1_tx_slots;
  logic [31:0] chan1_rx_slots;
  logic [31:0] chan2_slots;
  logic [31:0] chan3_slots;
  logic odd_frame;
  logic aligned;
  logic [7:0] reg_idx;
  logic wr_take;
  logic mapped;
  logic [31:0] next_prdata;

  assign reg_idx = paddr[9:2];
  assign wr_take = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    mapped = 1'b1;
    next_prdata = 32'h0000_0000;
    case (reg_idx)
      HSB_IDX_PARITY_SEL: next_prdata = {26'h0, parity_sel};
      HSB_IDX_CHAN1_MASK: next_prdata = {24'h0, chan_mask[0]};
      HSB_IDX_CHAN2_MASK: next_prdata = {24'h0, chan_mask[1]};
      HSB_IDX_CHAN3_MASK: next_prdata = {24'h0, chan_mask[2]};
      HSB_IDX_CHAN1_TX_SLOTS: next_prdata = chan1_tx_slots;
      HSB_IDX_CHAN1_RX_SLOTS: next_prdata = chan1_rx_slots;
      HSB_IDX_CHAN2_SLOTS: next_prdata = chan2_slots;
      HSB_IDX_CHAN3_SLOTS: next_prdata = chan3_slots;
      HSB_IDX_STATUS: begin
        next_prdata[HSB_STAT_ODD_BIT] = odd_frame;
        next_prdata[HSB_STAT_ALIGNED_BIT] = aligned;
      end
      default: mapped = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0) begin
      mapped = 1'b0;
      next_prdata = 32'h0000_0000;
    end
  end

  // Answer is prepared in setup so pready, prdata and pslverr are flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      parity_sel <= HSB_PARITY_RESET;
    end else if (wr_take && reg_idx == HSB_IDX_PARITY_SEL) begin
      parity_sel <= pwdata[5:0];
    end
  end

  for (genvar c = 0; c < HSB_NUM_CHAN; c++) begin : g_mask
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        chan_mask[c] <= HSB_MASK_RESET;
      end else if (wr_take && reg_idx == HSB_IDX_CHAN1_MASK + 8'(c)) begin
        chan_mask[c] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan1_tx_slots <= HSB_SLOTS_RESET;
      chan1_rx_slots <= HSB_SLOTS_RESET;
      chan2_slots <= HSB_SLOTS_RESET;
      chan3_slots <= HSB_SLOTS_RESET;
    end else if (wr_take) begin
      if (reg_idx == HSB_IDX_CHAN1_TX_SLOTS) begin
        chan1_tx_slots <= pwdata;
      end
      if (reg_idx == HSB_IDX_CHAN1_RX_SLOTS) begin
        chan1_rx_slots <= pwdata;
      end
      if (reg_idx == HSB_IDX_CHAN2_SLOTS) begin
        chan2_slots <= pwdata;
      end
      if (reg_idx == HSB_IDX_CHAN3_SLOTS) begin
        chan3_slots <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Placement of each channel in the line stream
  // ----------------------------------------------------------------
  hsb_chan_cfg_t cfg [HSB_NUM_CHAN];
  logic [2:0] rx_sel;
  logic [2:0] tx_sel;

  assign cfg[0] = '{rx_slots: chan1_rx_slots, tx_slots: chan1_tx_slots,
                    mask: chan_mask[0], parity: parity_sel[1:0]};
  assign cfg[1] = '{rx_slots: chan2_slots, tx_slots: chan2_slots,
                    mask: chan_mask[1], parity: parity_sel[3:2]};
  assign cfg[2] = '{rx_slots: chan3_slots, tx_slots: chan3_slots,
                    mask: chan_mask[2], parity: parity_sel[5:4]};

  hsb_frame_parity u_parity (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .frame_start(frame_start),
    .mf_start(mf_start),
    .odd_frame(odd_frame),
    .aligned(aligned)
  );

  for (genvar c = 0; c < HSB_NUM_CHAN; c++) begin : g_chan
    hsb_chan_gate u_gate (
      .cfg(cfg[c]),
      .pos(line_pos),
      .odd_frame(odd_frame),
      .rx_sel(rx_sel[c]),
      .tx_sel(tx_sel[c])
    );

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        chan_rx_valid[c] <= 1'b0;
        chan_rx_bit[c] <= 1'b0;
        chan_tx_pull[c] <= 1'b0;
      end else begin
        chan_rx_valid[c] <= rx_sel[c];
        chan_rx_bit[c] <= rx_sel[c] & line_rx_bit;
        chan_tx_pull[c] <= tx_sel[c];
      end
    end
  end

  // Overlapping placement is software's fault; lowest channel wins then
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_tx_out <= 1'b0;
    end else if (tx_sel[0]) begin
      line_tx_out <= chan_tx_bit[0];
    end else if (tx_sel[1]) begin
      line_tx_out <= chan_tx_bit[1];
    end else if (tx_sel[2]) begin
      line_tx_out <= chan_tx_bit[2];
    end else begin
      line_tx_out <= line_tx_in;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Reset-value checks hold only until software first writes
  logic cfg_written;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_written <= 1'b0;
    end else if (wr_take) begin
      cfg_written <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Stream checks, one cycle after the position was offered
  // ----------------------------------------------------------------
  sequence pos_bit_masked(int c);
    line_pos.valid && !chan_mask[c][line_pos.bitpos];
  endsequence

  sequence pos_in_frame(int c);
    line_pos.valid && cfg[c].parity == HSB_PAR_ODD && !odd_frame;
  endsequence

  sequence pos_even_only(int c);
    line_pos.valid && cfg[c].parity == HSB_PAR_EVEN && odd_frame;
  endsequence

  // Code 11 is undefined; this block chose to carry nothing for it
  sequence pos_code_unused(int c);
    line_pos.valid && cfg[c].parity == 2'h3;
  endsequence

  parity_reset_zero_a: assert property (!cfg_written |-> parity_sel == 6'h00)
    else $error("frame selection not zero before first write");
  mask_reset_ones_a: assert property (!cfg_written |-> chan_mask[1] == 8'hff)
    else $error("mask not all ones before first write");
  mf_first_odd_a: assert property (mf_start |=> odd_frame)
    else $error("multiframe did not start on odd frame");
  frame_alternate_a: assert property (frame_start && !mf_start
    |=> odd_frame != $past(odd_frame))
    else $error("frame parity did not alternate");
  odd_only_rx_a: assert property (pos_in_frame(0) |=> !chan_rx_valid[0])
    else $error("odd-only channel took an even frame");
  odd_only_tx_a: assert property (pos_in_frame(1) |=> !chan_tx_pull[1])
    else $error("odd-only channel sent in an even frame");
  even_only_both_a: assert property (pos_even_only(2)
    |=> !chan_rx_valid[2] && !chan_tx_pull[2])
    else $error("even-only channel used an odd frame");
  unused_code_a: assert property (pos_code_unused(0)
    |=> !chan_rx_valid[0] && !chan_tx_pull[0])
    else $error("channel with unused frame code carried data");
  mask_blocks_both_a: assert property (pos_bit_masked(2)
    |=> !chan_rx_valid[2] && !chan_tx_pull[2])
    else $error("masked bit used by a channel");
  mask_common_a: assert property ((chan_rx_valid[0] || chan_tx_pull[0])
    |-> $past(chan_mask[0][line_pos.bitpos]))
    else $error("channel 1 used a masked bit");
  chan1_tx_slot_a: assert property (chan_tx_pull[0]
    |-> $past(chan1_tx_slots[line_pos.slot]))
    else $error("channel 1 sent outside its transmit slots");
  chan1_rx_slot_a: assert property (chan_rx_valid[0]
    |-> $past(chan1_rx_slots[line_pos.slot]))
    else $error("channel 1 received outside its receive slots");
  chan2_rx_slot_a: assert property (chan_rx_valid[1]
    |-> $past(chan2_slots[line_pos.slot])
    && $past(chan_mask[1][line_pos.bitpos]))
    else $error("channel 2 received outside its slots");
  chan3_tx_slot_a: assert property (chan_tx_pull[2]
    |-> $past(chan3_slots[line_pos.slot]))
    else $error("channel 3 sent outside its slots");
  rx_bit_copy_a: assert property (chan_rx_valid[0]
    |-> chan_rx_bit[0] == $past(line_rx_bit))
    else $error("channel 1 received a wrong bit");
  rx_bit_quiet_a: assert property (!chan_rx_valid[1] |-> !chan_rx_bit[1])
    else $error("channel 2 bit moved without valid");
  tx_bit_taken_a: assert property (tx_sel[0]
    |=> line_tx_out == $past(chan_tx_bit[0]))
    else $error("channel 1 bit not placed on the line");
  passthrough_a: assert property (tx_sel == 3'h0 |=> line_tx_out == $past(line_tx_in))
    else $error("unselected position was overwritten");

  // ----------------------------------------------------------------
  // Register bus answer checks
  // ----------------------------------------------------------------
  // Zero wait states: a longer pready would let a write land twice
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error shown without ready");
  unmapped_error_a: assert property (psel && !penable && !pready && !mapped
    |=> pready && pslverr)
    else $error("unmapped access not refused");
  mask_write_a: assert property (wr_take && reg_idx == HSB_IDX_CHAN2_MASK
    |=> chan_mask[1] == $past(pwdata[7:0]))
    else $error("mask write not taken");

endmodule

// ---- bench/hsb_hdlc_model.sv ----
module hsb_hdlc_model
  import hsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [2:0] chan_tx_pull,
  output logic [2:0] chan_tx_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] sr [3];

  // Engine steps only after chan_tx_pull asks for its bit, even if a lower channel won the line, never on its own
  always_ff @(posedge ref_clk or negedge arst_n) begin
    for (int c = 0; c < HSB_NUM_CHAN; c++) begin
      if (!arst_n) begin
        sr[c] <= 8'h5a + 8'(c);
      end else if (chan_tx_pull[c]) begin
        sr[c] <= {sr[c][6:0], sr[c][7] ^ sr[c][5] ^ sr[c][4] ^ sr[c][3]};
      end
    end
  end

  assign chan_tx_bit = {sr[2][7], sr[1][7], sr[0][7]};
endmodule

// ---- bench/tb_top.sv ----
module tb_top
  import hsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, arst_n, psel, penable, pwrite, frame_start, mf_start;
  logic line_rx_bit, line_tx_in, pready, pslverr, line_tx_out, odd, vld_d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rs;
  hsb_pos_t line_pos;
  logic [2:0] chan_tx_bit, chan_rx_valid, chan_rx_bit, chan_tx_pull;
  logic [31:0] txs [3];
  logic [31:0] rxs [3];
  logic [7:0] msk [3];
  logic [1:0] par [3];
  logic [9:0] q [$];
  int n_fail, n_tests, cyc;

  hsb_slot_bit_select hsb_slot_bit_select_i (.ref_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_start, .mf_start, .line_pos,
    .line_rx_bit, .line_tx_in, .chan_tx_bit, .line_tx_out, .chan_rx_valid, .chan_rx_bit,
    .chan_tx_pull);
  hsb_hdlc_model hsb_hdlc_model_i (.ref_clk, .arst_n, .chan_tx_pull, .chan_tx_bit);

  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end

  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function logic pok(logic [1:0] p);
    return p == 2'h0 || (p == 2'h1 && odd) || (p == 2'h2 && !odd);
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
           output logic [31:0] r, output logic err);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // ----------------------------------------
  // Stream: idle cycle after each position
  // ----------------------------------------
  // The gap lets the engine step after a pull before its next bit is used
  task pos(input logic [4:0] s, input logic [2:0] b);
    logic [31:0] r;
    logic [2:0] rv, sl, pl;
    logic to;
    r = rnd();
    @(posedge ref_clk);
    line_pos <= {1'b1, s, b};
    line_rx_bit <= r[0];
    line_tx_in <= r[1];
    @(negedge ref_clk);
    for (int c = 0; c < 3; c++) begin
      rv[c] = rxs[c][s] & msk[c][b] & pok(par[c]);
      sl[c] = txs[c][s] & msk[c][b] & pok(par[c]);
    end
    pl = sl[0] ? 3'h1 : sl[1] ? 3'h2 : sl[2] ? 3'h4 : 3'h0;
    to = (|pl) ? |(pl & chan_tx_bit) : r[1];
    q.push_back({to, rv, rv & {3{r[0]}}, pl});
    @(posedge ref_clk);
    line_pos.valid <= 0;
  endtask

  task frame(input logic m);
    @(posedge ref_clk);
    frame_start <= 1;
    mf_start <= m;
    @(posedge ref_clk);
    frame_start <= 0;
    mf_start <= 0;
    odd = m | !odd;
    for (int s = 1; s < 4; s++) for (int b = 0; b < 8; b++) pos(s[4:0], b[2:0]);
  endtask

  always @(posedge ref_clk) vld_d <= line_pos.valid;

  always @(negedge ref_clk) begin
    if (vld_d) begin
      if (q.size() == 0) chk(1, 0);
      else chk({line_tx_out, chan_rx_valid, chan_rx_bit, chan_tx_pull}, q.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    int k;
    logic [31:0] r;
    logic e;
    logic [5:0] pv [4];
    rs = 95;
    odd = 1;
    n_fail = 0;
    n_tests = 0;
    arst_n = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {frame_start, mf_start, line_pos, line_rx_bit, line_tx_in} = '0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1;
    for (k = 0; k < 8; k++) begin
      apb(0, 8'ha0 + k[7:0], 0, r, e);
      chk(r, (k inside {[1:3]}) ? 32'hff : 32'h0);
    end
    apb(0, HSB_IDX_STATUS, 0, r, e);
    chk(r, 32'h1);
    apb(0, 8'ha9, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("test reset values done");
    r = rnd();
    msk = '{r[7:0], r[15:8], ~r[15:8]};
    txs = '{32'h2, 32'h8, 32'h8};
    rxs = '{32'h4, 32'h8, 32'h8};
    for (k = 0; k < 3; k++) apb(1, 8'ha1 + k[7:0], {24'h0, msk[k]}, r, e);
    apb(1, HSB_IDX_CHAN1_TX_SLOTS, txs[0], r, e);
    apb(1, HSB_IDX_CHAN1_RX_SLOTS, rxs[0], r, e);
    apb(1, HSB_IDX_CHAN2_SLOTS, txs[1], r, e);
    apb(1, HSB_IDX_CHAN3_SLOTS, txs[2], r, e);
    for (k = 0; k < 3; k++) begin
      apb(0, 8'ha1 + k[7:0], 0, r, e);
      chk(r, {24'h0, msk[k]});
    end
    pv = '{6'h24, 6'h1b, 6'h06, 6'h39};
    for (k = 0; k < 4; k++) begin
      apb(1, HSB_IDX_PARITY_SEL, {26'h0, pv[k]}, r, e);
      par = '{pv[k][1:0], pv[k][3:2], pv[k][5:4]};
      frame(1);
      frame(0);
      frame(0);
      frame(0);
      frame(1);
      apb(0, HSB_IDX_STATUS, 0, r, e);
      chk(r, 32'h3);
      $display("test frame selection %0d done", k);
    end
    repeat (3) @(posedge ref_clk);
    chk(q.size(), 0);
    close_out();
  end
endmodule
